// ### adcc_pkg.sv
// Register map, field layout and reset values of the conversion control block
package adcc_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h08;

  // Control register field positions
  localparam int GO_BIT   = 7;
  localparam int RSVD_BIT = 6;
  localparam int REF_BIT  = 5;
  localparam int CONTINUOUS_SELECT_BIT = 4;
  localparam int CHAN_LSB = 0;
  localparam int CHAN_W   = 4;

  // Interrupt status and mask layout
  localparam int IRQ_W         = 2;
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_RSTRT_BIT = 1;

  // Reset values
  localparam logic [7:0]       CTRL_RESET = 8'h20;
  localparam logic [IRQ_W-1:0] IRQ_RESET  = 2'h0;

endpackage

// ### adcc_conv_seq.sv
// Conversion tracker: launches, restarts and retires conversions of the converter core
`timescale 1ns/1ps

module adcc_conv_seq (
  input  wire logic mclk,        // System clock
  input  wire logic srst,        // Synchronous reset, active high
  input  wire logic go_wr,       // Software wrote one to the go bit, one cycle
  input  wire logic conv_done,   // Core finished a conversion, one cycle
  input  wire logic continuous,  // Continuous conversion selected
  output logic      busy,        // Conversion in progress
  output logic      conv_start,  // Start pulse to the core
  output logic      done_evt,    // A conversion completed, one cycle
  output logic      restart_evt  // A running conversion was restarted, one cycle
);

  typedef struct packed {
    logic busy;
    logic start;
    logic done_evt;
    logic restart_evt;
  } adcc_seq_t;

  adcc_seq_t seq_q;
  adcc_seq_t seq_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next state; a software go beats a completion in the same cycle
  always_comb begin
    seq_d             = seq_q;
    seq_d.start       = 1'b0;
    seq_d.done_evt    = 1'b0;
    seq_d.restart_evt = 1'b0;
    if (go_wr) begin
      seq_d.busy        = 1'b1;
      seq_d.start       = 1'b1;
      seq_d.restart_evt = seq_q.busy;
    end else if (seq_q.busy && conv_done) begin
      seq_d.done_evt = 1'b1;
      if (continuous) begin
        seq_d.start = 1'b1;               // Continuous mode chains the next conversion
      end else begin
        seq_d.busy = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (srst) begin
      seq_q <= '0;
    end else begin
      seq_q <= seq_d;
    end
  end

  assign busy        = seq_q.busy;
  assign conv_start  = seq_q.start;
  assign done_evt    = seq_q.done_evt;
  assign restart_evt = seq_q.restart_evt;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_go_starts: assert property (@(posedge mclk) disable iff (srst)
    go_wr |=> busy && conv_start)
    else $error("go write did not start a conversion");

  a_done_clears: assert property (@(posedge mclk) disable iff (srst)
    busy && conv_done && !go_wr && !continuous |=> !busy ##1 !conv_start)
    else $error("completion did not clear busy");

  a_write_wins: assert property (@(posedge mclk) disable iff (srst)
    go_wr && conv_done |=> busy && !done_evt)
    else $error("completion beat a simultaneous go write");

  a_busy_holds: assert property (@(posedge mclk) disable iff (srst)
    busy && !conv_done |=> busy)
    else $error("busy dropped without completion");

  c_restart: cover property (@(posedge mclk) disable iff (srst) restart_evt);
  c_chain: cover property (@(posedge mclk) disable iff (srst) done_evt && conv_start);

endmodule // adcc_conv_seq

// ### adcc_top.sv
// APB register block and converter core control for analog-to-digital conversions
//
// Summary of operation
// - Writing one to the go bit starts a new conversion and pulses the start line to the core.
// - Writing one to the go bit while a conversion runs abandons it and starts it again.
// - The go bit reads one while a conversion runs and drops to zero when it completes with the continuous select bit clear.
// - Writing zero to the go bit changes nothing and never stops a running conversion.
// - Reference select zero enables the internal reference, one disables it for an external one.
// - The control register also holds the input channel field and the continuous select bit.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps

module adcc_top (
  input  wire logic        mclk,            // System clock, 250 MHz
  input  wire logic        srst,            // Synchronous reset, active high
  input  wire logic        psel,            // APB select
  input  wire logic        penable,         // APB enable
  input  wire logic        pwrite,          // APB direction, high for write
  input  wire logic [7:0]  paddr,           // APB byte address
  input  wire logic [31:0] pwdata,          // APB write data
  input  wire logic [3:0]  pstrb,           // APB byte strobes
  output logic      [31:0] prdata,          // APB read data
  output logic             pready,          // APB ready
  output logic             pslverr,         // APB error, unmapped address
  output logic             irq,             // Interrupt, level high
  input  wire logic        conv_done,       // Core completed a conversion, one cycle
  output logic             conv_start,      // Start or restart the core, one cycle
  output logic             ref_int_enable,  // Internal reference generator enable
  output logic [3:0]       channel_select,  // Analog input channel
  output logic             continuous_mode  // Continuous conversion selected
);

  typedef struct packed {
    logic                           pready;
    logic [31:0]                    prdata;
    logic                           pslverr;
    logic                           ref_int_en;
    logic                           continuous_select;
    logic [adcc_pkg::CHAN_W-1:0]    chan;
    logic [adcc_pkg::IRQ_W-1:0]     status;
    logic [adcc_pkg::IRQ_W-1:0]     mask;
    logic                           irq;
  } adcc_regs_t;

  adcc_regs_t r_q;
  adcc_regs_t r_d;

  logic                        busy;
  logic                        done_evt;
  logic                        restart_evt;
  logic                        wr_fire;
  logic                        go_wr;
  logic [adcc_pkg::IRQ_W-1:0]  evt_vec;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == adcc_pkg::ADDR_CTRL) || (a == adcc_pkg::ADDR_IRQ_STATUS) ||
                (a == adcc_pkg::ADDR_IRQ_MASK);
  endfunction

  // Control byte as software sees it; reserved bit always reads zero
  function automatic logic [7:0] ctrl_view(input logic go, input logic ref_en, input logic continuous_select,
                                           input logic [adcc_pkg::CHAN_W-1:0] chan);
    logic [7:0] v;
    v = 8'h00;
    v[adcc_pkg::GO_BIT]   = go;
    v[adcc_pkg::REF_BIT]  = ~ref_en;
    v[adcc_pkg::CONTINUOUS_SELECT_BIT] = continuous_select;
    v[adcc_pkg::CHAN_LSB +: adcc_pkg::CHAN_W] = chan;
    ctrl_view = v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write strobe: only the access edge on which pready is high commits
  assign wr_fire = psel && penable && r_q.pready && pwrite && pstrb[0];
  // A zero in the go bit leaves the sequencer alone
  assign go_wr   = wr_fire && (paddr == adcc_pkg::ADDR_CTRL) && pwdata[adcc_pkg::GO_BIT];
  assign evt_vec = {restart_evt, done_evt};

  ////////////////////////////////////////////////////////////////////////////
  // Conversion tracker
  adcc_conv_seq u_seq (
    .mclk        (mclk),
    .srst        (srst),
    .go_wr       (go_wr),
    .conv_done   (conv_done),
    .continuous  (r_q.continuous_select),
    .busy        (busy),
    .conv_start  (conv_start),
    .done_evt    (done_evt),
    .restart_evt (restart_evt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register file next state
  always_comb begin
    r_d        = r_q;
    r_d.pready = 1'b0;
    // One wait state: ready rises in the second access cycle, data already stable
    if (psel && penable && !r_q.pready) begin
      r_d.pready  = 1'b1;
      r_d.pslverr = !is_mapped(paddr);
      r_d.prdata  = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          adcc_pkg::ADDR_CTRL:       r_d.prdata[7:0] = ctrl_view(busy, r_q.ref_int_en, r_q.continuous_select, r_q.chan);
          adcc_pkg::ADDR_IRQ_STATUS: r_d.prdata[adcc_pkg::IRQ_W-1:0] = r_q.status;
          adcc_pkg::ADDR_IRQ_MASK:   r_d.prdata[adcc_pkg::IRQ_W-1:0] = r_q.mask;
          default:                   r_d.prdata = 32'h0000_0000;
        endcase
      end
    end
    if (wr_fire) begin
      unique case (paddr)
        adcc_pkg::ADDR_CTRL: begin
          // Reserved bit is dropped rather than stored
          r_d.ref_int_en = ~pwdata[adcc_pkg::REF_BIT];
          r_d.continuous_select       = pwdata[adcc_pkg::CONTINUOUS_SELECT_BIT];
          r_d.chan       = pwdata[adcc_pkg::CHAN_LSB +: adcc_pkg::CHAN_W];
        end
        adcc_pkg::ADDR_IRQ_STATUS: r_d.status = r_q.status & ~pwdata[adcc_pkg::IRQ_W-1:0];
        adcc_pkg::ADDR_IRQ_MASK:   r_d.mask   = pwdata[adcc_pkg::IRQ_W-1:0];
        default:                   r_d.mask   = r_q.mask;
      endcase
    end
    // Events are applied last so a set in the clearing cycle survives
    r_d.status = r_d.status | evt_vec;
    r_d.irq    = |(r_d.status & r_d.mask);
  end

  // Register update
  always_ff @(posedge mclk) begin
    if (srst) begin
      r_q            <= '0;
      r_q.ref_int_en <= ~adcc_pkg::CTRL_RESET[adcc_pkg::REF_BIT];
      r_q.continuous_select       <= adcc_pkg::CTRL_RESET[adcc_pkg::CONTINUOUS_SELECT_BIT];
      r_q.chan       <= adcc_pkg::CTRL_RESET[adcc_pkg::CHAN_LSB +: adcc_pkg::CHAN_W];
      r_q.status     <= adcc_pkg::IRQ_RESET;
      r_q.mask       <= adcc_pkg::IRQ_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the register struct
  assign prdata          = r_q.prdata;
  assign pready          = r_q.pready;
  assign pslverr         = r_q.pslverr;
  assign irq             = r_q.irq;
  assign ref_int_enable  = r_q.ref_int_en;
  assign channel_select  = r_q.chan;
  assign continuous_mode = r_q.continuous_select;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_zero_write_idle: assert property (@(posedge mclk) disable iff (srst)
    wr_fire && paddr == adcc_pkg::ADDR_CTRL && !pwdata[adcc_pkg::GO_BIT] && !busy |=> !conv_start)
    else $error("zero write to go bit started a conversion");

  a_zero_write_run: assert property (@(posedge mclk) disable iff (srst)
    wr_fire && paddr == adcc_pkg::ADDR_CTRL && !pwdata[adcc_pkg::GO_BIT] && busy && !conv_done |=> busy)
    else $error("zero write to go bit stopped a conversion");

  a_ref_select: assert property (@(posedge mclk) disable iff (srst)
    wr_fire && paddr == adcc_pkg::ADDR_CTRL |=> ref_int_enable == !$past(pwdata[adcc_pkg::REF_BIT]))
    else $error("reference enable does not follow the select bit");

  a_restart_pulse: assert property (@(posedge mclk) disable iff (srst)
    go_wr && busy |=> conv_start ##1 !conv_start)
    else $error("restart did not give one start pulse");

  a_go_readback: assert property (@(posedge mclk) disable iff (srst)
    pready && !pwrite && paddr == adcc_pkg::ADDR_CTRL |-> prdata[adcc_pkg::GO_BIT] == $past(busy))
    else $error("go bit readback differs from conversion state");

  a_rsvd_zero: assert property (@(posedge mclk) disable iff (srst)
    pready && !pwrite && paddr == adcc_pkg::ADDR_CTRL |-> prdata[adcc_pkg::RSVD_BIT] == 1'b0)
    else $error("reserved bit read back nonzero");

  a_done_sticky: assert property (@(posedge mclk) disable iff (srst)
    done_evt |=> r_q.status[adcc_pkg::IRQ_DONE_BIT])
    else $error("done event lost from status");

  a_irq_level: assert property (@(posedge mclk) disable iff (srst)
    irq == |(r_q.status & r_q.mask))
    else $error("interrupt does not match masked status");

  a_ready_pulse: assert property (@(posedge mclk) disable iff (srst)
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  c_single_conv: cover property (@(posedge mclk) disable iff (srst) conv_start ##[1:20] done_evt);
  c_irq_fire: cover property (@(posedge mclk) disable iff (srst) $rose(irq));
  c_unmapped: cover property (@(posedge mclk) disable iff (srst) pready && pslverr);

endmodule // adcc_top

// ### adcc_core_model.sv
// Behavioural converter core that answers the latest start pulse after a set delay
`timescale 1ns/1ps

module adcc_core_model (
  input  wire logic       mclk,       // System clock
  input  wire logic       srst,       // Synchronous reset, active high
  input  wire logic       conv_start, // Start or restart from the block
  input  wire logic [7:0] delay,      // Cycles from start to done, one or more
  output logic            conv_done   // Conversion finished, one cycle
);
  ////////////////////////////////////////
  logic [7:0] cnt_q; // Cycles left, zero while idle

  // A new start drops the running count, so a restart really begins again
  always_ff @(posedge mclk) begin
    conv_done <= 1'b0;
    if (srst) begin
      cnt_q <= 8'h00;
    end else if (conv_start) begin
      cnt_q <= delay;
    end else if (cnt_q != 8'h00) begin
      cnt_q     <= cnt_q - 8'h01;
      conv_done <= (cnt_q == 8'h01);
    end
  end
endmodule // adcc_core_model

// ### tb.sv
// Self-checking bench for the conversion control block over APB
`timescale 1ns/1ps

module tb;
  logic        mclk, srst, psel, penable, pwrite, pready, pslverr, irq, err;
  logic        conv_done, conv_start, ref_int_enable, continuous_mode;
  logic [7:0]  paddr, core_dly;
  logic [3:0]  pstrb, channel_select;
  logic [31:0] pwdata, prdata, rd;
  int          errors = 0, n_tests = 0, n_start = 0, n0;

  adcc_top DUT (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .conv_done(conv_done), .conv_start(conv_start), .ref_int_enable(ref_int_enable),
    .channel_select(channel_select), .continuous_mode(continuous_mode));
  adcc_core_model core (.mclk(mclk), .srst(srst), .conv_start(conv_start), .delay(core_dly),
    .conv_done(conv_done));

  ////////////////////////////////////////
  // Start pulses seen by the core
  always @(posedge mclk) if (conv_start === 1'b1) n_start <= n_start + 1;

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask

  // One APB transfer; the slave's latency is not assumed, only bounded
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin
      errors++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic experr = 1'b0);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(err, experr);
  endtask

  // Poll the go bit until the conversion has retired
  task automatic wait_idle;
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, adcc_pkg::ADDR_CTRL, 32'h0);
      if (rd[7] === 1'b0) break;
    end
    if (rd[7] !== 1'b0) begin
      errors++;
      report_and_stop();
    end
  endtask

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial begin
    srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; pstrb = 4'hF; core_dly = 8'h28;
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    rdchk(adcc_pkg::ADDR_CTRL, 32'h20);
    chk(ref_int_enable, 1'b0);
    rdchk(adcc_pkg::ADDR_IRQ_MASK, 32'h0);
    $display("Test reset done");
    n0 = n_start;
    apb(1'b1, adcc_pkg::ADDR_CTRL, 32'h83);
    rdchk(adcc_pkg::ADDR_CTRL, 32'h83);
    chk(n_start - n0, 1);
    chk({ref_int_enable, channel_select}, 5'h13);
    apb(1'b1, adcc_pkg::ADDR_CTRL, 32'h03);
    rdchk(adcc_pkg::ADDR_CTRL, 32'h83);
    $display("Test start done");
    apb(1'b1, adcc_pkg::ADDR_IRQ_MASK, 32'h3);
    apb(1'b1, adcc_pkg::ADDR_CTRL, 32'h83);
    rdchk(adcc_pkg::ADDR_IRQ_STATUS, 32'h2);
    chk({irq, 8'(n_start - n0)}, 9'h102);
    apb(1'b1, adcc_pkg::ADDR_IRQ_STATUS, 32'h2);
    wait_idle();
    rdchk(adcc_pkg::ADDR_IRQ_STATUS, 32'h1);
    chk(irq, 1'b1);
    apb(1'b1, adcc_pkg::ADDR_IRQ_MASK, 32'h2);
    rdchk(adcc_pkg::ADDR_IRQ_MASK, 32'h2);
    chk(irq, 1'b0);
    apb(1'b1, adcc_pkg::ADDR_IRQ_STATUS, 32'h1);
    rdchk(adcc_pkg::ADDR_IRQ_STATUS, 32'h0);
    $display("Test restart and interrupt done");
    core_dly <= 8'h04;
    n0 = n_start;
    apb(1'b1, adcc_pkg::ADDR_CTRL, 32'h95);
    repeat (30) @(posedge mclk);
    rdchk(adcc_pkg::ADDR_CTRL, 32'h95);
    chk({continuous_mode, 1'(n_start - n0 > 2)}, 2'h3);
    apb(1'b1, adcc_pkg::ADDR_CTRL, 32'h25);
    wait_idle();
    rdchk(adcc_pkg::ADDR_CTRL, 32'h25);
    chk({ref_int_enable, continuous_mode}, 2'h0);
    rdchk(8'h0C, 32'h0, 1'b1);
    $display("Test continuous and unmapped done");
    core_dly <= 8'h02;
    apb(1'b1, adcc_pkg::ADDR_IRQ_STATUS, 32'h3);
    apb(1'b1, adcc_pkg::ADDR_CTRL, 32'hA5);
    // Two-cycle core and back-to-back writes put the second go on the done pulse
    apb(1'b1, adcc_pkg::ADDR_CTRL, 32'hA5);
    rdchk(adcc_pkg::ADDR_IRQ_STATUS, 32'h2);
    wait_idle();
    n0 = n_start;
    apb(1'b1, adcc_pkg::ADDR_CTRL, 32'h05);
    rdchk(adcc_pkg::ADDR_CTRL, 32'h05);
    chk({ref_int_enable, 8'(n_start - n0)}, 9'h100);
    $display("Test write priority and idle zero write done");
    report_and_stop();
  end
endmodule // tb
